// >>> radio_cal_pa_pkg.sv
package radio_cal_pa_pkg;

  // Register offsets as seen by the host interface
  localparam logic [7:0] ADDR_CFG0   = 8'h18;
  localparam logic [7:0] ADDR_FRONT  = 8'h22;
  localparam logic [7:0] ADDR_CAL_CP = 8'h23;

  // Values after reset
  localparam logic [1:0] RST_AUTOCAL  = 2'h0;
  localparam logic [1:0] RST_PO_SEL   = 2'h1;
  localparam logic [1:0] RST_CFG0_RSV = 2'h0;
  localparam logic [1:0] RST_LO_BUF   = 2'h1;
  localparam logic [2:0] RST_AMP_IDX  = 3'h0;
  localparam logic [1:0] RST_CP_CFG   = 2'h2;
  localparam logic [1:0] RST_CP_EN    = 2'h2;
  localparam logic [3:0] RST_CP_RES   = 4'h9;

  // Field positions
  localparam int AUTOCAL_LSB = 4;
  localparam int PO_SEL_LSB  = 2;
  localparam int LO_BUF_LSB  = 4;
  localparam int CP_CFG_LSB  = 6;
  localparam int CP_EN_LSB   = 4;

  // Calibration trigger selections
  localparam logic [1:0] AUTOCAL_NEVER      = 2'h0;
  localparam logic [1:0] AUTOCAL_IDLE_TO_TX = 2'h1;
  localparam logic [1:0] AUTOCAL_TX_TO_IDLE = 2'h2;
  localparam logic [1:0] AUTOCAL_EVERY_4TH  = 2'h3;
  localparam logic [1:0] AUTOCAL_LAST_OF_4  = 2'h3;

  // Counter widths and counts of cycles
  localparam int          RIPPLE_BITS   = 6;
  localparam logic [5:0]  RIPPLE_LAST   = 6'h3f;
  localparam int          EXPIRY_BITS   = 9;
  localparam int          RAMP_STEP_DEF = 4;

  typedef enum logic [2:0] {
    RS_IDLE     = 3'b001,
    RS_TX       = 3'b010,
    RS_SYNTH_ON = 3'b100
  } radio_state_e;

  typedef enum logic [2:0] {
    CAL_IDLE = 3'b001,
    CAL_CP   = 3'b010,
    CAL_REST = 3'b100
  } cal_state_e;

  // Expiry count selected by the power-on timeout field
  function automatic logic [8:0] po_expiries(input logic [1:0] sel);
    case (sel)
      2'h0:    po_expiries = 9'h001;
      2'h1:    po_expiries = 9'h010;
      2'h2:    po_expiries = 9'h040;
      default: po_expiries = 9'h100;
    endcase
  endfunction

endpackage

// >>> power_on_timer.sv
`timescale 1ns/1ps
module power_on_timer
  import radio_cal_pa_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       arst_n,
  // Control
  input  wire logic       xosc_stable,
  input  wire logic [1:0] timeout_sel,
  // Status
  output logic            chip_ready_low
);

  logic [RIPPLE_BITS-1:0] ripple_reg;
  logic [EXPIRY_BITS-1:0] expiry_reg;
  logic                   ready_low_reg;
  wire                    expire = (ripple_reg == RIPPLE_LAST);
  wire                    done   = (expiry_reg >= po_expiries(timeout_sel));

  // Oscillator loss restarts the whole wait
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ripple_reg    <= '0;
      expiry_reg    <= '0;
      ready_low_reg <= 1'b1;
    end else if (!xosc_stable) begin
      ripple_reg    <= '0;
      expiry_reg    <= '0;
      ready_low_reg <= 1'b1;
    end else if (!done) begin
      ripple_reg    <= ripple_reg + 6'h01;
      if (expire) expiry_reg <= expiry_reg + 9'h001;
    end else begin
      ready_low_reg <= 1'b0;
    end
  end

  assign chip_ready_low = ready_low_reg;

endmodule

// >>> radio_cal_pa_config.sv
`timescale 1ns/1ps
// Summary of operation
// - With auto-calibration select 00 calibration starts only on the manual strobe.
// - With select 01 calibration starts on each move from IDLE into TX or synth-on.
// - With select 10 calibration starts on each move from TX back to IDLE.
// - With select 11 only every fourth TX-to-IDLE move starts a calibration.
// - Chip-ready stays high after the oscillator settles until the selected number of ripple counter expiries has passed.
// - Timeout select 00/01/10/11 means 1/16/64/256 ripple counter expiries.
// - The reserved low two bits of config0 survive the sleep state.
// - The amplifier power index picks one of eight power table entries.
// - In ASK a one uses the indexed entry and a zero uses entry zero.
// - Entries zero up to the index are stepped through for ASK shaping and ramps.
// - A zero charge-pump calibration enable skips the charge-pump stage.
// - The charge-pump result sits in the low four bits of the calibration register.
// - Host-written calibration results are used directly without recalibrating.
// - The LO buffer current field is read/write with reset value 1.
module radio_cal_pa_config
  import radio_cal_pa_pkg::*;
#(
  parameter int RAMP_STEP = RAMP_STEP_DEF
)(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       arst_n,
  // Register access from the serial interface
  input  wire logic       reg_wr_en,
  input  wire logic       reg_rd_en,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  // Power table write port
  input  wire logic       table_wr_en,
  input  wire logic [2:0] table_wr_idx,
  input  wire logic [7:0] table_wdata,
  // Radio control state
  input  wire logic [2:0] radio_state,
  input  wire logic       manual_calibrate_strobe,
  input  wire logic       xosc_stable_async,
  // Calibration engine handshake
  input  wire logic       cal_cp_done,
  input  wire logic [3:0] cal_cp_result,
  input  wire logic       cal_rest_done,
  output logic            cal_cp_active,
  output logic            cal_rest_active,
  // Transmit front end
  input  wire logic       tx_active,
  input  wire logic       ask_mode,
  input  wire logic       tx_bit,
  output logic      [7:0] pa_setting,
  output logic      [2:0] pa_index,
  output logic      [1:0] lo_buffer_current,
  output logic      [7:0] synth_calibration_charge_pump,
  output logic            chip_ready_low
);

  // Register fields
  logic [1:0] auto_cal_select_reg;
  logic [1:0] power_on_timeout_sel_reg;
  logic [1:0] cfg0_rsv_reg;
  logic [1:0] lo_buffer_current_reg;
  logic [2:0] amp_power_index_reg;
  logic [1:0] cp_cfg_reg;
  logic [1:0] charge_pump_cal_enable_reg;
  logic [3:0] cp_result_reg;
  logic [7:0] rdata_reg;
  logic [7:0] power_setting_table [8];

  wire wr_cfg0   = reg_wr_en && (reg_addr == ADDR_CFG0);
  wire wr_front  = reg_wr_en && (reg_addr == ADDR_FRONT);
  wire wr_cal_cp = reg_wr_en && (reg_addr == ADDR_CAL_CP);

  wire [7:0] cfg0_view  = {2'h0, auto_cal_select_reg, power_on_timeout_sel_reg, cfg0_rsv_reg};
  wire [7:0] front_view = {2'h0, lo_buffer_current_reg, 1'b0, amp_power_index_reg};
  wire [7:0] fscal_view = {cp_cfg_reg, charge_pump_cal_enable_reg, cp_result_reg};

  // Unused bits are never stored, so they read zero
  wire [7:0] rd_mux = (reg_addr == ADDR_CFG0)   ? cfg0_view  :
                      (reg_addr == ADDR_FRONT)  ? front_view :
                      (reg_addr == ADDR_CAL_CP) ? fscal_view : 8'h00;

  // Calibration state
  cal_state_e   cal_reg, cal_next;
  radio_state_e prev_state_reg;
  logic [1:0]   tx_idle_cnt_reg;

  wire idle_to_tx = (prev_state_reg == RS_IDLE) &&
                    ((radio_state == RS_TX) || (radio_state == RS_SYNTH_ON));
  wire tx_to_idle = (prev_state_reg == RS_TX) && (radio_state == RS_IDLE);
  wire fourth     = tx_idle_cnt_reg == AUTOCAL_LAST_OF_4;

  wire auto_trig = ((auto_cal_select_reg == AUTOCAL_IDLE_TO_TX) && idle_to_tx) ||
                   ((auto_cal_select_reg == AUTOCAL_TX_TO_IDLE) && tx_to_idle) ||
                   ((auto_cal_select_reg == AUTOCAL_EVERY_4TH) && tx_to_idle && fourth);
  // Select 00 contributes no automatic term
  wire cal_trig  = manual_calibrate_strobe || auto_trig;
  wire cp_stage  = charge_pump_cal_enable_reg != 2'h0;
  wire cp_store  = (cal_reg == CAL_CP) && cal_cp_done;

  always_comb begin
    cal_next = cal_reg;
    case (cal_reg)
      CAL_IDLE: if (cal_trig) cal_next = cp_stage ? CAL_CP : CAL_REST;
      CAL_CP:   if (cal_cp_done) cal_next = CAL_REST;
      CAL_REST: if (cal_rest_done) cal_next = CAL_IDLE;
      default:  cal_next = CAL_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cal_reg         <= CAL_IDLE;
      prev_state_reg  <= RS_IDLE;
      tx_idle_cnt_reg <= 2'h0;
    end else begin
      cal_reg        <= cal_next;
      prev_state_reg <= radio_state_e'(radio_state);
      if (tx_to_idle && auto_cal_select_reg == AUTOCAL_EVERY_4TH)
        tx_idle_cnt_reg <= tx_idle_cnt_reg + 2'h1;
    end
  end

  // Register file; sleep only stops the oscillator, so all fields hold
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      auto_cal_select_reg        <= RST_AUTOCAL;
      power_on_timeout_sel_reg   <= RST_PO_SEL;
      cfg0_rsv_reg               <= RST_CFG0_RSV;
      lo_buffer_current_reg      <= RST_LO_BUF;
      amp_power_index_reg        <= RST_AMP_IDX;
      cp_cfg_reg                 <= RST_CP_CFG;
      charge_pump_cal_enable_reg <= RST_CP_EN;
      cp_result_reg              <= RST_CP_RES;
    end else begin
      if (wr_cfg0) begin
        auto_cal_select_reg      <= reg_wdata[AUTOCAL_LSB +: 2];
        power_on_timeout_sel_reg <= reg_wdata[PO_SEL_LSB +: 2];
      end
      if (wr_front) begin
        lo_buffer_current_reg <= reg_wdata[LO_BUF_LSB +: 2];
        amp_power_index_reg   <= reg_wdata[2:0];
      end
      if (wr_cal_cp) begin
        cp_cfg_reg                 <= reg_wdata[CP_CFG_LSB +: 2];
        charge_pump_cal_enable_reg <= reg_wdata[CP_EN_LSB +: 2];
      end
      // Hardware result wins over a host write in the same cycle
      if (cp_store)
        cp_result_reg <= cal_cp_result;
      else if (wr_cal_cp)
        cp_result_reg <= reg_wdata[3:0];
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) rdata_reg <= 8'h00;
    else if (reg_rd_en) rdata_reg <= rd_mux;
  end

  always_ff @(posedge clk) begin
    if (table_wr_en) power_setting_table[table_wr_idx] <= table_wdata;
  end

  // Power ramp: one index step per RAMP_STEP cycles
  logic [2:0]  pa_idx_reg;
  logic [7:0]  pa_set_reg;
  logic [15:0] step_cnt_reg;
  wire  [2:0]  pa_target = !tx_active ? 3'h0 :
                           (ask_mode && !tx_bit) ? 3'h0 :
                           amp_power_index_reg;
  wire         step_now  = step_cnt_reg == 16'(RAMP_STEP - 1);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pa_idx_reg   <= 3'h0;
      step_cnt_reg <= 16'h0000;
      pa_set_reg   <= 8'h00;
    end else begin
      step_cnt_reg <= (step_now || pa_idx_reg == pa_target) ? 16'h0000 :
                      step_cnt_reg + 16'h0001;
      if (step_now && pa_idx_reg < pa_target) pa_idx_reg <= pa_idx_reg + 3'h1;
      else if (step_now && pa_idx_reg > pa_target) pa_idx_reg <= pa_idx_reg - 3'h1;
      pa_set_reg <= power_setting_table[pa_idx_reg];
    end
  end

  // Oscillator flag comes from the analog side
  logic xosc_meta_reg;
  logic xosc_sync_reg;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      xosc_meta_reg <= 1'b0;
      xosc_sync_reg <= 1'b0;
    end else begin
      xosc_meta_reg <= xosc_stable_async;
      xosc_sync_reg <= xosc_meta_reg;
    end
  end

  power_on_timer u_po_timer (
    .clk            (clk),
    .arst_n         (arst_n),
    .xosc_stable    (xosc_sync_reg),
    .timeout_sel    (power_on_timeout_sel_reg),
    .chip_ready_low (chip_ready_low)
  );

  assign reg_rdata                     = rdata_reg;
  assign cal_cp_active                 = cal_reg == CAL_CP;
  assign cal_rest_active               = cal_reg == CAL_REST;
  assign pa_index                      = pa_idx_reg;
  assign pa_setting                    = pa_set_reg;
  assign lo_buffer_current             = lo_buffer_current_reg;
  assign synth_calibration_charge_pump = fscal_view;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  AST_NEVER_AUTO: assert property (
    (auto_cal_select_reg == AUTOCAL_NEVER && !manual_calibrate_strobe && cal_reg == CAL_IDLE)
      |=> cal_reg == CAL_IDLE)
    else $error("Calibration started without strobe");
  AST_IDLE_TO_TX: assert property (
    (auto_cal_select_reg == AUTOCAL_IDLE_TO_TX && idle_to_tx && cal_reg == CAL_IDLE)
      |=> cal_reg != CAL_IDLE)
    else $error("No calibration on IDLE to TX");
  AST_TX_TO_IDLE: assert property (
    (auto_cal_select_reg == AUTOCAL_TX_TO_IDLE && tx_to_idle && cal_reg == CAL_IDLE)
      |=> cal_reg != CAL_IDLE)
    else $error("No calibration on TX to IDLE");
  AST_NOT_FOURTH: assert property (
    (auto_cal_select_reg == AUTOCAL_EVERY_4TH && tx_to_idle && !fourth &&
     !manual_calibrate_strobe && cal_reg == CAL_IDLE) |=> cal_reg == CAL_IDLE)
    else $error("Calibration on a non-fourth transition");
  AST_READY_HELD: assert property (
    !xosc_sync_reg |=> chip_ready_low)
    else $error("Chip ready low without stable oscillator");
  sequence s_stable_one;
    xosc_sync_reg && power_on_timeout_sel_reg == 2'h0 && chip_ready_low ##1
      xosc_sync_reg [*8];
  endsequence
  AST_READY_QUICK: assert property (
    s_stable_one |-> ##[0:64] (!chip_ready_low || !xosc_sync_reg ||
                               $changed(power_on_timeout_sel_reg)))
    else $error("Single expiry timeout too long");
  AST_CP_SKIP: assert property (
    (cal_reg == CAL_IDLE && cal_trig && !cp_stage) |=> cal_reg == CAL_REST)
    else $error("Charge pump stage not skipped");
  AST_CP_STORE: assert property (
    cp_store |=> cp_result_reg == $past(cal_cp_result))
    else $error("Charge pump result not stored");
  AST_HOST_RESULT: assert property (
    (wr_cal_cp && !cp_store) |=> synth_calibration_charge_pump[3:0] == $past(reg_wdata[3:0]))
    else $error("Host calibration value not used");
  AST_ASK_ZERO: assert property (
    (ask_mode && !tx_bit && tx_active) |=> pa_idx_reg <= $past(pa_idx_reg))
    else $error("Power index rose while sending ASK zero");
  AST_RAMP_STEP: assert property (
    1'b1 |=> (pa_idx_reg - $past(pa_idx_reg) == 3'h0 || pa_idx_reg - $past(pa_idx_reg) == 3'h1
              || $past(pa_idx_reg) - pa_idx_reg == 3'h1))
    else $error("Power index jumped more than one step");
  AST_UNUSED_ZERO: assert property (
    (reg_rd_en && reg_addr == ADDR_FRONT) |=> reg_rdata[7:6] == 2'h0 && reg_rdata[3] == 1'b0)
    else $error("Unused bits read nonzero");

endmodule

// >>> cal_engine_model.sv
`timescale 1ns/1ps
module cal_engine_model (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       arst_n,
  // Stage requests from the block
  input  wire logic       cp_active,
  input  wire logic       rest_active,
  // Scenario settings
  input  wire logic [3:0] delay,
  input  wire logic [3:0] result,
  // Answers
  output logic            cp_done,
  output logic      [3:0] cp_result,
  output logic            rest_done
);
  logic [4:0] cnt_reg;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n)
      cnt_reg <= 5'h00;
    else if (cp_done || rest_done || !(cp_active || rest_active))
      cnt_reg <= 5'h00;
    else
      cnt_reg <= cnt_reg + 5'h01;
  end

  assign cp_done   = cp_active && (cnt_reg == {1'b0, delay});
  assign rest_done = rest_active && (cnt_reg == {1'b0, delay});
  // Result valid only with the done pulse, so a late capture is caught
  assign cp_result = cp_done ? result : ~result;
endmodule

// >>> tb_radio_cal_pa_config.sv
`timescale 1ns/1ps
module tb_radio_cal_pa_config;
  import radio_cal_pa_pkg::*;
  logic       clk, arst_n, reg_wr_en, reg_rd_en, table_wr_en, strobe, xosc;
  logic       cp_done, rest_done, cp_act, rest_act, tx_active, ask_mode, tx_bit, rdy_low;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, table_wdata, pa_setting, cal3, v;
  logic [2:0] table_wr_idx, radio_state, pa_index, prev;
  logic [3:0] cp_res, dly, res;
  logic [1:0] lo_buf;
  logic [7:0] tbl [8];
  logic [7:0] exp_q [$];
  logic       rd_d, busy_d;
  int         fails, check_count, starts, st, n;
  int         po_cyc [4] = '{64, 1024, 4096, 16384};
  int         po_ord [4] = '{0, 1, 3, 2};

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  radio_cal_pa_config #(.RAMP_STEP(1)) i_dut (
    .clk(clk), .arst_n(arst_n), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .table_wr_en(table_wr_en), .table_wr_idx(table_wr_idx), .table_wdata(table_wdata),
    .radio_state(radio_state), .manual_calibrate_strobe(strobe), .xosc_stable_async(xosc),
    .cal_cp_done(cp_done), .cal_cp_result(cp_res), .cal_rest_done(rest_done),
    .cal_cp_active(cp_act), .cal_rest_active(rest_act), .tx_active(tx_active),
    .ask_mode(ask_mode), .tx_bit(tx_bit), .pa_setting(pa_setting), .pa_index(pa_index),
    .lo_buffer_current(lo_buf), .synth_calibration_charge_pump(cal3),
    .chip_ready_low(rdy_low));

  cal_engine_model i_cal (
    .clk(clk), .arst_n(arst_n), .cp_active(cp_act), .rest_active(rest_act),
    .delay(dly), .result(res), .cp_done(cp_done), .cp_result(cp_res),
    .rest_done(rest_done));

  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string m);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, m, seen, exp);
    end
  endtask

  // Read answers arrive one cycle after the request edge
  always @(posedge clk) begin
    rd_d <= reg_rd_en;
    busy_d <= cp_act | rest_act;
    if ((cp_act | rest_act) && !busy_d)
      starts <= starts + 1;
  end
  always @(negedge clk) begin
    if (rd_d === 1'b1 && exp_q.size() > 0)
      check(reg_rdata, exp_q.pop_front(), "register read");
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_wr_en = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk);
    reg_wr_en = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk);
    reg_rd_en = 1'b1;
    reg_addr = a;
    exp_q.push_back(e);
    @(negedge clk);
    reg_rd_en = 1'b0;
  endtask

  task automatic wait_idle();
    n = 0;
    while ((cp_act | rest_act) !== 1'b0 && n < 60) begin
      @(negedge clk);
      n++;
    end
    if (n == 60) begin
      fails++;
      give_verdict();
    end
  endtask

  // Four cycles cover the state compare plus the launch of a calibration
  task automatic move(input logic [2:0] s);
    @(negedge clk);
    radio_state = s;
    repeat (4) @(negedge clk);
    wait_idle();
  endtask

  task automatic pulse();
    dly = 4'($urandom_range(7));
    res = 4'($urandom);
    @(negedge clk);
    strobe = 1'b1;
    @(negedge clk);
    strobe = 1'b0;
  endtask

  initial begin
    {reg_wr_en, reg_rd_en, table_wr_en, strobe, xosc, tx_active, ask_mode, tx_bit} = '0;
    {reg_addr, reg_wdata, table_wdata, table_wr_idx} = '0;
    radio_state = RS_IDLE;
    dly = 4'h2;
    res = 4'h5;
    fails = 0;
    check_count = 0;
    starts = 0;
    arst_n = 1'b0;
    void'($urandom(32'h2507eb94));
    repeat (4) @(negedge clk);
    arst_n = 1'b1;
    check(rdy_low, 1'b1, "ready before oscillator");
    check(lo_buf, 2'h1, "buffer current reset");
    rd(ADDR_CFG0, 8'h04);
    rd(ADDR_FRONT, 8'h10);
    rd(ADDR_CAL_CP, 8'ha9);
    rd(8'h30, 8'h00);
    wr(ADDR_CFG0, 8'hff);
    rd(ADDR_CFG0, 8'h3c);
    v = 8'($urandom);
    wr(ADDR_FRONT, v);
    rd(ADDR_FRONT, v & 8'h37);
    check(lo_buf, v[5:4], "buffer current");
    v = 8'($urandom);
    wr(ADDR_CAL_CP, v);
    rd(ADDR_CAL_CP, v);
    check(cal3, v, "hop value in use");
    wr(ADDR_CAL_CP, 8'ha9);
    for (int s = 0; s < 3; s++) begin
      wr(ADDR_CFG0, {2'h0, 2'(s), 4'h4});
      st = starts;
      move(RS_TX);
      check(16'(starts - st), 16'(s == 1), "cal into tx");
      st = starts;
      move(RS_IDLE);
      check(16'(starts - st), 16'(s == 2), "cal into idle");
    end
    wr(ADDR_CFG0, 8'h14);
    st = starts;
    move(RS_SYNTH_ON);
    move(RS_IDLE);
    check(16'(starts - st), 16'h1, "cal into synth on");
    wr(ADDR_CFG0, 8'h34);
    for (int i = 1; i <= 4; i++) begin
      move(RS_TX);
      st = starts;
      move(RS_IDLE);
      check(16'(starts - st), 16'(i == 4), "every fourth");
    end
    wr(ADDR_CFG0, 8'h04);
    pulse();
    check({cp_act, rest_act}, 2'b10, "manual cal");
    wait_idle();
    rd(ADDR_CAL_CP, {4'ha, res});
    check(cal3[3:0], res, "cal result");
    wr(ADDR_CAL_CP, 8'h89);
    pulse();
    check({cp_act, rest_act}, 2'b01, "stage skipped");
    wait_idle();
    rd(ADDR_CAL_CP, 8'h89);
    for (int i = 0; i < 8; i++) begin
      tbl[i] = 8'($urandom);
      @(negedge clk);
      table_wr_en = 1'b1;
      table_wr_idx = 3'(i);
      table_wdata = tbl[i];
    end
    @(negedge clk);
    table_wr_en = 1'b0;
    wr(ADDR_FRONT, 8'h15);
    tx_active = 1'b1;
    prev = 3'h0;
    // Ramp may only climb one entry at a time
    for (int i = 0; i < 12; i++) begin
      @(negedge clk);
      check(16'(pa_index == prev || pa_index == prev + 3'h1), 16'h1, "ramp step");
      prev = pa_index;
    end
    check(pa_index, 3'h5, "ramp target");
    check(pa_setting, tbl[5], "indexed level");
    ask_mode = 1'b1;
    repeat (10) @(negedge clk);
    check(pa_setting, tbl[0], "ask zero");
    tx_bit = 1'b1;
    repeat (10) @(negedge clk);
    check(pa_setting, tbl[5], "ask one");
    tx_active = 1'b0;
    repeat (10) @(negedge clk);
    check(pa_index, 3'h0, "ramp down");
    foreach (po_ord[k]) begin
      wr(ADDR_CFG0, {4'h0, 2'(po_ord[k]), 2'h0});
      xosc = 1'b1;
      n = 0;
      while (rdy_low !== 1'b0 && n < 17000) begin
        @(negedge clk);
        n++;
      end
      st = n - po_cyc[po_ord[k]];
      check(16'(st >= 0 && st <= 6), 16'h1, "timeout");
      if (n == 17000)
        give_verdict();
      xosc = 1'b0;
      repeat (4) @(negedge clk);
      check(rdy_low, 1'b1, "ready drops");
    end
    give_verdict();
  end
endmodule
